// [core/pair_regs.sv]
// Identifier, advertisement and link-partner ability registers of the PHY
`timescale 1ns/1ps
`default_nettype none
`include "pair_defs.svh"

// Notes on behaviour
// - Identifier high: organisation, model, revision fields
// - Advertisement bit 15 next page, resets 0
// - Advertisement bit 13 local fault, resets 0
// - Advertisement bits 8..5 writable, reset to 1
// - Both 100Base-T4 bits always read 0
// - Selector field fixed at 00001
// - Partner ability bits 8..5 read-only, reset 0
module pair_regs
    import pair_pkg::*;
#(
    parameter logic [15:0] OUI_HIGH = 16'h1234,  // Arbitrary value
    parameter logic [5:0] OUI_LOW = 6'h2a,       // Arbitrary value
    parameter logic [5:0] MODEL = 6'h11,         // Arbitrary value
    parameter logic [3:0] REVISION = 4'h1        // Arbitrary value
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire pair_addr_t reg_addr,
    input wire logic reg_wr,
    input wire pair_word_t reg_wdata,
    output var pair_word_t reg_rdata,
    input wire logic page_rx,
    input wire pair_word_t page_word,
    output var pair_word_t adv_word
);

    // --------------------------------------------------------------
    // Advertisement state
    // --------------------------------------------------------------
    logic np_q, np_d;
    logic fault_q, fault_d;
    logic [3:0] abil_q, abil_d;
    pair_word_t lpa_q, lpa_d;
    pair_word_t rdata_q, rdata_d;
    pair_word_t id_high;
    pair_word_t adv_view;
    logic wr_adv;

    assign wr_adv = reg_wr && (reg_addr == `PAIR_ADDR_ADV);

    always_comb
    begin
        np_d = np_q;
        fault_d = fault_q;
        abil_d = abil_q;
        if (wr_adv)
        begin
            np_d = reg_wdata[`PAIR_ADV_NEXT_PAGE];
            fault_d = reg_wdata[`PAIR_ADV_LOCAL_FAULT];
            abil_d = reg_wdata[`PAIR_ADV_ABIL_MSB:`PAIR_ADV_ABIL_LSB];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            np_q <= `PAIR_ADV_NP_RST;
            fault_q <= `PAIR_ADV_FAULT_RST;
            abil_q <= `PAIR_ADV_ABIL_RST;
        end
        else
        begin
            np_q <= np_d;
            fault_q <= fault_d;
            abil_q <= abil_d;
        end
    end

    // --------------------------------------------------------------
    // Link-partner word, loaded from each received base page
    // --------------------------------------------------------------
    always_comb
    begin
        lpa_d = lpa_q;
        if (page_rx)
        begin
            lpa_d = page_word;
            lpa_d[`PAIR_LPA_T4] = 1'b0;
            // Reserved bits forced low so a noisy partner cannot set them
            lpa_d[`PAIR_LPA_RSVD_MSB:`PAIR_LPA_RSVD_LSB] = 3'h0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            lpa_q <= `PAIR_LPA_RST;
        else
            lpa_q <= lpa_d;
    end

    // --------------------------------------------------------------
    // Read path; software writes never reach the partner word
    // --------------------------------------------------------------
    always_comb
    begin
        id_high = {OUI_LOW, MODEL, REVISION};
        adv_view = 16'h0000;
        adv_view[`PAIR_ADV_NEXT_PAGE] = np_q;
        adv_view[`PAIR_ADV_LOCAL_FAULT] = fault_q;
        adv_view[`PAIR_ADV_ABIL_MSB:`PAIR_ADV_ABIL_LSB] = abil_q;
        adv_view[`PAIR_SEL_MSB:`PAIR_SEL_LSB] = `PAIR_SELECTOR;
    end

    assign adv_word = adv_view;

    // Registered read costs a cycle but keeps the data output glitch free
    always_comb
    begin
        case (reg_addr)
            `PAIR_ADDR_ID_LOW: rdata_d = OUI_HIGH;
            `PAIR_ADDR_ID_HIGH: rdata_d = id_high;
            `PAIR_ADDR_ADV: rdata_d = adv_view;
            `PAIR_ADDR_LPA: rdata_d = lpa_q;
            default: rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            rdata_q <= 16'h0000;
        else
            rdata_q <= rdata_d;
    end

    assign reg_rdata = rdata_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    sequence s_adv_write;
        reg_wr && reg_addr == `PAIR_ADDR_ADV;
    endsequence

    property p_np_write;
        @(posedge sys_clk) disable iff (!nrst)
        s_adv_write |=> np_q == $past(reg_wdata[15]);
    endproperty
    a_np_write: assert property (p_np_write) else $error("Next page bit not written");

    property p_fault_write;
        @(posedge sys_clk) disable iff (!nrst)
        s_adv_write |=> fault_q == $past(reg_wdata[13]);
    endproperty
    a_fault_write: assert property (p_fault_write) else $error("Fault bit not written");

    property p_abil_write;
        @(posedge sys_clk) disable iff (!nrst)
        s_adv_write |=> abil_q == $past(reg_wdata[8:5]);
    endproperty
    a_abil_write: assert property (p_abil_write) else $error("Ability bits not written");

    property p_abil_reset;
        @(posedge sys_clk) $rose(nrst) |-> abil_q == 4'hf && !np_q && !fault_q;
    endproperty
    a_abil_reset: assert property (p_abil_reset) else $error("Advertisement reset wrong");

    property p_t4_zero;
        @(posedge sys_clk) disable iff (!nrst)
        !adv_word[9] && !lpa_q[9];
    endproperty
    a_t4_zero: assert property (p_t4_zero) else $error("T4 bit set");

    property p_selector;
        @(posedge sys_clk) disable iff (!nrst)
        $past(reg_addr) == `PAIR_ADDR_ADV && $past(nrst) |-> reg_rdata[4:0] == 5'h01;
    endproperty
    a_selector: assert property (p_selector) else $error("Selector not 00001");

    property p_lpa_hold;
        @(posedge sys_clk) disable iff (!nrst)
        !page_rx |=> $stable(lpa_q);
    endproperty
    a_lpa_hold: assert property (p_lpa_hold) else $error("Partner word changed");

    property p_lpa_load;
        @(posedge sys_clk) disable iff (!nrst)
        page_rx |=> lpa_q[8:5] == $past(page_word[8:5]) && lpa_q[15:13] == $past(page_word[15:13]);
    endproperty
    a_lpa_load: assert property (p_lpa_load) else $error("Partner word not loaded");

    property p_id_read;
        @(posedge sys_clk) disable iff (!nrst)
        reg_addr == `PAIR_ADDR_ID_HIGH ##1 $past(nrst) |-> reg_rdata[9:4] == MODEL;
    endproperty
    a_id_read: assert property (p_id_read) else $error("Model field wrong");

    property p_id_high;
        @(posedge sys_clk) disable iff (!nrst)
        $past(nrst) && $past(reg_addr) == `PAIR_ADDR_ID_HIGH
            |-> reg_rdata[15:10] == OUI_LOW && reg_rdata[3:0] == REVISION;
    endproperty
    a_id_high: assert property (p_id_high) else $error("Identifier fields wrong");

    property p_id_low;
        @(posedge sys_clk) disable iff (!nrst)
        $past(nrst) && $past(reg_addr) == `PAIR_ADDR_ID_LOW |-> reg_rdata == OUI_HIGH;
    endproperty
    a_id_low: assert property (p_id_low) else $error("Low identifier word wrong");

    property p_other_write;
        @(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr != `PAIR_ADDR_ADV |=> $stable(adv_word);
    endproperty
    a_other_write: assert property (p_other_write) else $error("Stray write changed adv");

    property p_lpa_reset;
        @(posedge sys_clk) $rose(nrst) |-> lpa_q == `PAIR_LPA_RST && reg_rdata == 16'h0000;
    endproperty
    a_lpa_reset: assert property (p_lpa_reset) else $error("Partner word reset wrong");

    sequence s_page_taken;
        page_rx;
    endsequence

    property p_lpa_fields;
        @(posedge sys_clk) disable iff (!nrst)
        s_page_taken |=> lpa_q[12:9] == 4'h0
            && lpa_q[4:0] == $past(page_word[4:0]) && lpa_q[14] == $past(page_word[14]);
    endproperty
    a_lpa_fields: assert property (p_lpa_fields) else $error("Partner fields wrong");

endmodule : pair_regs
`default_nettype wire

// [shared/pair_defs.svh]
// Register offsets, field positions and reset values of the identifier and negotiation bank
`ifndef PAIR_DEFS_SVH
`define PAIR_DEFS_SVH

`define PAIR_ADDR_ID_LOW 5'h02
`define PAIR_ADDR_ID_HIGH 5'h03
`define PAIR_ADDR_ADV 5'h04
`define PAIR_ADDR_LPA 5'h05

`define PAIR_ID_OUI_MSB 15
`define PAIR_ID_OUI_LSB 10
`define PAIR_ID_MODEL_MSB 9
`define PAIR_ID_MODEL_LSB 4
`define PAIR_ID_REV_MSB 3
`define PAIR_ID_REV_LSB 0

`define PAIR_ADV_NEXT_PAGE 15
`define PAIR_ADV_LOCAL_FAULT 13
`define PAIR_ADV_T4 9
`define PAIR_ADV_ABIL_MSB 8
`define PAIR_ADV_ABIL_LSB 5
`define PAIR_LPA_T4 9
`define PAIR_LPA_ABIL_MSB 8
`define PAIR_LPA_ABIL_LSB 5
`define PAIR_LPA_RSVD_MSB 12
`define PAIR_LPA_RSVD_LSB 10
`define PAIR_SEL_MSB 4
`define PAIR_SEL_LSB 0

`define PAIR_ADV_NP_RST 1'h0
`define PAIR_ADV_FAULT_RST 1'h0
`define PAIR_ADV_ABIL_RST 4'hf
`define PAIR_SELECTOR 5'h01
`define PAIR_LPA_RST 16'h0000

`endif

// [shared/pair_pkg.sv]
// Types for the identifier and negotiation register bank
`default_nettype none
package pair_pkg;
    typedef logic [15:0] pair_word_t;
    typedef logic [4:0] pair_addr_t;
endpackage : pair_pkg
`default_nettype wire

// [testbench/pair_link_partner.sv]
// Link partner model that delivers base pages
`timescale 1ns/1ps
`default_nettype none
module pair_link_partner
    import pair_pkg::*;
(
    input wire logic sys_clk,
    input wire logic send,
    input wire pair_word_t word,
    output logic page_rx,
    output var pair_word_t page_word
);
    initial page_rx = 1'b0;
    initial page_word = 16'h5a5a;
    // Word is valid only with the pulse; it toggles otherwise so no stale value passes
    always @(posedge sys_clk)
    begin
        page_rx <= send;
        page_word <= send ? word : ~page_word;
    end
endmodule : pair_link_partner
`default_nettype wire

// [testbench/pair_regs_tb.sv]
// Self-checking bench for the identifier and negotiation registers
`timescale 1ns/1ps
`default_nettype none
module pair_regs_tb
    import pair_pkg::*;
;
    localparam pair_word_t ID_HIGH = {6'h15, 6'h0c, 4'h3};
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    pair_addr_t reg_addr = 5'h00;
    logic reg_wr = 1'b0;
    pair_word_t reg_wdata = 16'h0000;
    pair_word_t reg_rdata;
    logic send = 1'b0;
    pair_word_t word = 16'h0000;
    logic page_rx;
    pair_word_t page_word;
    pair_word_t adv_word;
    int mismatches = 0;
    int checks_done = 0;
    always #50 sys_clk = ~sys_clk;
    // Identifier values are arbitrary
    pair_regs #(.OUI_HIGH(16'h0abc), .OUI_LOW(6'h15), .MODEL(6'h0c), .REVISION(4'h3))
        i_pair_regs (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .page_rx(page_rx),
        .page_word(page_word), .adv_word(adv_word));
    pair_link_partner i_pair_link_partner (.sys_clk(sys_clk), .send(send), .word(word),
        .page_rx(page_rx), .page_word(page_word));
    // ----------
    // Bus tasks
    // ----------
    task automatic chk(input string what, input pair_word_t exp, input pair_word_t got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input pair_addr_t a, input pair_word_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data is registered, so sample one cycle after the address
    task automatic rd(input pair_addr_t a, input pair_word_t exp);
        @(posedge sys_clk);
        reg_addr <= a;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("reg_rdata", exp, reg_rdata);
    endtask : rd
    task automatic page(input pair_word_t w);
        @(posedge sys_clk);
        send <= 1'b1;
        word <= w;
        @(posedge sys_clk);
        send <= 1'b0;
    endtask : page
    task automatic close_out();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(5'h02, 16'h0abc);
        rd(5'h03, ID_HIGH);
        rd(5'h04, 16'h01e1);
        chk("adv_word", 16'h01e1, adv_word);
        rd(5'h05, 16'h0000);
        rd(5'h1f, 16'h0000);
        wr(5'h04, 16'hffff);
        rd(5'h04, 16'ha1e1);
        wr(5'h04, 16'h0000);
        rd(5'h04, 16'h0001);
        chk("adv_word", 16'h0001, adv_word);
        wr(5'h04, 16'h8140);
        rd(5'h04, 16'h8141);
        chk("adv_word", 16'h8141, adv_word);
        wr(5'h05, 16'hffff);
        wr(5'h03, 16'h0000);
        rd(5'h05, 16'h0000);
        rd(5'h03, ID_HIGH);
        page(16'hffff);
        rd(5'h05, 16'he1ff);
        page(16'h8021);
        rd(5'h05, 16'h8021);
        page(16'h4140);
        rd(5'h05, 16'h4140);
        @(posedge sys_clk);
        nrst <= 1'b0;
        @(posedge sys_clk);
        nrst <= 1'b1;
        rd(5'h04, 16'h01e1);
        rd(5'h05, 16'h0000);
        close_out();
    end
    // Tests need about 64 cycles; allow 2000, about thirty times that
    initial
    begin
        #(2000 * 100);
        mismatches++;
        close_out();
    end
endmodule : pair_regs_tb
`default_nettype wire
